// ---- logic/cabo_alu.v ----
`timescale 1ns/1ps
`include "cabo_defines.vh"
// Add and AND datapath with flag generation
module cabo_alu (
  input wire [7:0] opa,
  input wire [7:0] opb,
  input wire cin,
  input wire do_and,
  output reg [7:0] res,
  output reg [4:0] flags
);
  reg [8:0] sum;
  reg [4:0] low;
  // Flags for add come from carry chain; AND keeps only N and Z meaningful
  always @* begin
    sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    low = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    res = do_and ? (opa & opb) : sum[7:0];
    flags = 5'h00;
    flags[`CABO_FLG_C] = sum[8];
    flags[`CABO_FLG_DC] = low[4]; // RULE_13
    flags[`CABO_FLG_OV] = (opa[7] == opb[7]) && (sum[7] != opa[7]); // RULE_13
    flags[`CABO_FLG_N] = res[7];
    flags[`CABO_FLG_Z] = (res == 8'h00);
  end
endmodule

// ---- logic/cabo_core.v ----
// Function
// RULE_01 - Literal add: working reg plus literal into working reg, five flags
// RULE_02 - File add: working reg plus file, destination by d, five flags
// RULE_03 - Access bit zero uses access bank; one uses bank select register
// RULE_04 - Add with carry: working reg plus file plus carry, to d
// RULE_05 - Literal AND into working reg, only negative and zero change
// RULE_06 - File AND, destination by d, only negative and zero change
// RULE_07 - Taken branch loads branch address plus two plus twice offset
// RULE_08 - Branch one cycle untaken, two taken, second cycle idle
// RULE_09 - Carry branches: taken on carry set, or on carry clear
// RULE_10 - Negative branches: taken on negative set, or on negative clear
// RULE_11 - No-overflow branch taken when overflow flag is clear
// RULE_12 - Bit clear zeroes one file bit in one cycle, no flags
// RULE_13 - Overflow is signed 8-bit wrap; digit carry is carry out of bit 3
`timescale 1ns/1ps
`include "cabo_defines.vh"
module cabo_core #(
  parameter PC_W = 21
) (
  input wire mclk,
  input wire sys_rst,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [7:0] file_rdata,
  input wire [3:0] bank_select_reg,
  output reg [11:0] file_addr,
  output reg [7:0] file_wdata,
  output reg file_we,
  output reg [7:0] working_reg,
  output reg [4:0] status_flags,
  output reg [PC_W-1:0] prog_counter,
  output reg stall_cycle,
  output reg instr_done,
  output reg unsupported
);
  wire [7:0] opc = instr_word[15:8];
  wire [7:0] lit = instr_word[7:0];
  wire dest_file = instr_word[9];
  wire acc_bit = instr_word[8];
  wire [2:0] bit_idx = instr_word[11:9];

  reg is_addlit, is_andlit, is_addf, is_addfc, is_andf, is_bclr, is_br;
  reg br_cond;
  // Opcode decode
  always @* begin
    is_addlit = (opc == `CABO_OP_ADDLIT); // RULE_01
    is_andlit = (opc == `CABO_OP_ANDLIT); // RULE_05
    is_addf = (opc[7:2] == `CABO_OP6_ADDF); // RULE_02
    is_addfc = (opc[7:2] == `CABO_OP6_ADDFC); // RULE_04
    is_andf = (opc[7:2] == `CABO_OP6_ANDF); // RULE_06
    is_bclr = (opc[7:4] == `CABO_OP4_BITCLR); // RULE_12
    is_br = 1'b1;
    br_cond = 1'b0;
    case (opc)
      `CABO_OP_BRC: br_cond = status_flags[`CABO_FLG_C]; // RULE_09
      `CABO_OP_BRNC: br_cond = ~status_flags[`CABO_FLG_C]; // RULE_09
      `CABO_OP_BRN: br_cond = status_flags[`CABO_FLG_N]; // RULE_10
      `CABO_OP_BRNN: br_cond = ~status_flags[`CABO_FLG_N]; // RULE_10
      `CABO_OP_BRNOV: br_cond = ~status_flags[`CABO_FLG_OV]; // RULE_11
      default: is_br = 1'b0;
    endcase
  end

  // Data address; the access bank is split so both low RAM and the
  // special registers are reachable without touching the bank register
  reg [11:0] next_addr;
  always @* begin
    if (acc_bit) begin
      next_addr = {bank_select_reg, lit}; // RULE_03
    end else if (lit < `CABO_ACC_SPLIT) begin
      next_addr = {4'h0, lit}; // RULE_03
    end else begin
      next_addr = {`CABO_ACC_HIBANK, lit}; // RULE_03
    end
  end

  wire file_op = is_addf | is_addfc | is_andf | is_bclr;
  wire lit_op = is_addlit | is_andlit;
  wire [7:0] alu_b = lit_op ? lit : file_rdata;
  wire alu_cin = is_addfc & status_flags[`CABO_FLG_C]; // RULE_04
  wire alu_and = is_andlit | is_andf;
  wire [7:0] alu_res;
  wire [4:0] alu_flags;

  cabo_alu u_alu (
    .opa(working_reg),
    .opb(alu_b),
    .cin(alu_cin),
    .do_and(alu_and),
    .res(alu_res),
    .flags(alu_flags)
  );

  // Bit clear mask, one term per bit
  wire [7:0] clr_val;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_clr
      assign clr_val[gi] = file_rdata[gi] & (bit_idx != gi); // RULE_12
    end
  endgenerate

  // Branch target: sign-extended offset doubled, added to pc plus 2
  wire [PC_W-1:0] br_off = {{(PC_W-9){lit[7]}}, lit, 1'b0};
  wire [PC_W-1:0] pc_next = prog_counter + {{(PC_W-2){1'b0}}, 2'b10};
  wire [PC_W-1:0] br_target = pc_next + br_off; // RULE_07

  // File address is registered at the edge that takes the word, so it
  // appears one cycle after decode; the caller supplies file_rdata with the word
  always @(posedge mclk) begin
    if (sys_rst) begin
      file_addr <= 12'h000;
    end else begin
      file_addr <= next_addr;
    end
  end

  // Execute: one instruction per accepted cycle, unless the idle slot
  // of a taken branch is pending
  always @(posedge mclk) begin
    if (sys_rst) begin
      working_reg <= `CABO_RST_BYTE;
      status_flags <= `CABO_RST_FLAGS;
      prog_counter <= `CABO_RST_PC;
      file_wdata <= `CABO_RST_BYTE;
      file_we <= 1'b0;
      stall_cycle <= 1'b0;
      instr_done <= 1'b0;
      unsupported <= 1'b0;
    end else begin
      file_we <= 1'b0;
      instr_done <= 1'b0;
      unsupported <= 1'b0;
      if (stall_cycle) begin
        // Second cycle of a taken branch does nothing
        stall_cycle <= 1'b0; // RULE_08
        instr_done <= 1'b1;
      end else if (instr_valid) begin
        if (is_br) begin
          // Branches never touch the flags
          if (br_cond) begin
            prog_counter <= br_target; // RULE_07
            stall_cycle <= 1'b1; // RULE_08
          end else begin
            prog_counter <= pc_next; // RULE_08
            instr_done <= 1'b1;
          end
        end else begin
          prog_counter <= pc_next;
          instr_done <= 1'b1;
          if (lit_op) begin
            working_reg <= alu_res; // RULE_01 RULE_05
          end else if (is_bclr) begin
            file_wdata <= clr_val; // RULE_12
            file_we <= 1'b1;
          end else if (file_op) begin
            if (dest_file) begin
              file_wdata <= alu_res; // RULE_02 RULE_06
              file_we <= 1'b1;
            end else begin
              working_reg <= alu_res; // RULE_02 RULE_06
            end
          end else begin
            unsupported <= 1'b1;
          end
          // Flag update: add ops all five, AND ops only N and Z
          if (is_addlit | is_addf | is_addfc) begin
            status_flags <= alu_flags; // RULE_01 RULE_02 RULE_04
          end else if (alu_and) begin
            status_flags[`CABO_FLG_N] <= alu_flags[`CABO_FLG_N]; // RULE_05
            status_flags[`CABO_FLG_Z] <= alu_flags[`CABO_FLG_Z]; // RULE_06
          end
        end
      end
    end
  end
endmodule

// ---- logic/cabo_defines.vh ----
`ifndef CABO_DEFINES_VH
`define CABO_DEFINES_VH
// Opcode upper bytes and fields
`define CABO_OP_ADDLIT 8'h0f
`define CABO_OP_ANDLIT 8'h0b
`define CABO_OP6_ADDF 6'h09
`define CABO_OP6_ADDFC 6'h08
`define CABO_OP6_ANDF 6'h05
`define CABO_OP4_BITCLR 4'h9
`define CABO_OP_BRC 8'he2
`define CABO_OP_BRNC 8'he3
`define CABO_OP_BRN 8'he6
`define CABO_OP_BRNN 8'he7
`define CABO_OP_BRNOV 8'he5
// Flag bit positions in the flag vector
`define CABO_FLG_C 0
`define CABO_FLG_DC 1
`define CABO_FLG_Z 2
`define CABO_FLG_OV 3
`define CABO_FLG_N 4
// Reset values
`define CABO_RST_BYTE 8'h00
`define CABO_RST_FLAGS 5'h00
`define CABO_RST_PC 21'h000000
// Access bank: low half of bank 0, upper half of the top bank
`define CABO_ACC_SPLIT 8'h80
`define CABO_ACC_HIBANK 4'hf
`endif

// ---- verif/cabo_core_assertions.sv ----
`timescale 1ns/1ps
module cabo_chk #(
  parameter PC_W = 21
) (
  input wire mclk,
  input wire sys_rst,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [7:0] file_rdata,
  input wire [3:0] bank_select_reg,
  input wire [11:0] file_addr,
  input wire [7:0] file_wdata,
  input wire file_we,
  input wire [7:0] working_reg,
  input wire [4:0] status_flags,
  input wire [PC_W-1:0] prog_counter,
  input wire stall_cycle,
  input wire instr_done,
  input wire unsupported
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Decode of the word taken at this edge; stall edges take nothing
  wire go = instr_valid && !stall_cycle;
  wire [7:0] op = instr_word[15:8];
  wire [4:0] f = status_flags;
  wire [PC_W-1:0] ofs = {{(PC_W-9){instr_word[7]}}, instr_word[7:0], 1'b0};
  wire tk = go && (op == 8'he2 && f[0] || op == 8'he3 && !f[0] ||
    op == 8'he6 && f[4] || op == 8'he7 && !f[4] || op == 8'he5 && !f[3]);
  wire nt = go && !tk && (op == 8'he2 || op == 8'he3 || op == 8'he5 ||
    op == 8'he6 || op == 8'he7);
  wire bclr = go && instr_word[15:12] == 4'h9;
  chk_addlit_sum: assert property (go && op == 8'h0f |=>
    working_reg == $past(working_reg) + $past(instr_word[7:0]))
    else $error("literal add sum wrong");
  chk_br_target: assert property (tk |=> stall_cycle &&
    prog_counter == PC_W'($past(prog_counter) + 2 + $past(ofs)))
    else $error("branch target wrong");
  chk_br_idle: assert property (tk |=> !instr_done ##1
    (!stall_cycle && instr_done)) else $error("taken branch timing");
  chk_br_skip: assert property (nt |=> !stall_cycle && instr_done
    && prog_counter == PC_W'($past(prog_counter) + 2))
    else $error("untaken branch wrong");
  chk_br_flags: assert property (tk |=> ##1
    f == $past(status_flags, 2)) else $error("branch moved flags");
  chk_and_keep: assert property (go && op == 8'h0b |=>
    (f & 5'h0b) == ($past(status_flags) & 5'h0b))
    else $error("literal and moved flags");
  chk_bclr_bit: assert property (bclr |=> file_we && $stable(f) &&
    file_wdata == ($past(file_rdata) & ~(8'h01 << $past(instr_word[11:9]))))
    else $error("bit clear wrong");
  chk_bank_addr: assert property (bclr && !instr_word[7] |=>
    file_addr == {($past(instr_word[8]) ? $past(bank_select_reg) : 4'h0),
    $past(instr_word[7:0])}) else $error("data address wrong");
  cover property (tk);
  cover property (nt);
  cover property (bclr && instr_word[8]);
endmodule
bind cabo_core cabo_chk #(.PC_W(PC_W)) u_cabo_chk (.mclk(mclk),
  .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
  .file_rdata(file_rdata), .bank_select_reg(bank_select_reg),
  .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
  .working_reg(working_reg), .status_flags(status_flags),
  .prog_counter(prog_counter), .stall_cycle(stall_cycle),
  .instr_done(instr_done), .unsupported(unsupported));

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg instr_valid = 1'b0;
  reg [15:0] instr_word = 16'h0000;
  reg [7:0] file_rdata = 8'h00;
  reg [3:0] bank_select_reg = 4'h3;
  wire [11:0] file_addr;
  wire [7:0] file_wdata, working_reg;
  wire [4:0] status_flags;
  wire [20:0] prog_counter;
  wire file_we, stall_cycle, instr_done, unsupported;
  integer bad_count = 0;
  integer n_checks = 0;
  integer i;
  reg [20:0] epc;
  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;
  cabo_core u_cabo_core (.mclk(mclk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .file_rdata(file_rdata), .bank_select_reg(bank_select_reg),
    .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
    .working_reg(working_reg), .status_flags(status_flags),
    .prog_counter(prog_counter), .stall_cycle(stall_cycle),
    .instr_done(instr_done), .unsupported(unsupported));
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One word per call; valid drops at the taking edge so it is taken once
  task run(input [15:0] w, input [7:0] r);
    begin
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_word <= w;
      file_rdata <= r;
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
      epc = epc + 21'h2;
    end
  endtask
  task chk(input [7:0] w, input [4:0] f);
    begin
      cmp(working_reg, w);
      cmp(status_flags, f);
      cmp(prog_counter, epc);
    end
  endtask
  task br(input [7:0] op, input [7:0] n, input tk);
    begin
      run({op, n}, 8'h00);
      if (tk)
        epc = epc + {{12{n[7]}}, n, 1'b0};
      cmp(stall_cycle, tk);
      cmp(instr_done, !tk);
      cmp(prog_counter, epc);
      if (tk) begin
        @(posedge mclk);
        #1;
        cmp(instr_done, 1'b1);
      end
    end
  endtask
  task t_alu;
    begin
      @(posedge mclk);
      sys_rst <= 1'b0;
      epc = 21'h0;
      run(16'h0f15, 8'h00);
      chk(8'h15, 5'h00);
      run(16'h0feb, 8'h00);
      chk(8'h00, 5'h07);
      run(16'h0f7f, 8'h00);
      run(16'h0f01, 8'h00);
      chk(8'h80, 5'h1a);
      run(16'h2410, 8'hc2);
      chk(8'h42, 5'h09);
      cmp(file_addr, 12'h010);
      run(16'h2720, 8'h01);
      cmp(file_wdata, 8'h43);
      cmp(file_addr, 12'h320);
      run(16'h0fff, 8'h00);
      run(16'h0b80, 8'h00);
      chk(8'h00, 5'h07);
      run(16'h2090, 8'h02);
      chk(8'h03, 5'h00);
      cmp(file_addr, 12'hf90);
      run(16'h1605, 8'h83);
      cmp(file_wdata, 8'h03);
      cmp(file_we, 1'b1);
    end
  endtask
  task t_br;
    begin
      br(8'he2, 8'h05, 1'b0);
      br(8'he3, 8'h80, 1'b1);
      br(8'he6, 8'h7f, 1'b0);
      br(8'he7, 8'h7f, 1'b1);
      br(8'he5, 8'h10, 1'b1);
      run(16'h0f7d, 8'h00);
      br(8'he6, 8'hf0, 1'b1);
      br(8'he7, 8'h01, 1'b0);
      br(8'he5, 8'h01, 1'b0);
      run(16'h0f80, 8'h00);
      br(8'he2, 8'h03, 1'b1);
      br(8'he3, 8'h03, 1'b0);
      chk(8'h00, 5'h0d);
      // Each bit index clears exactly its own bit, no flag moves
      for (i = 0; i < 8; i = i + 1) begin
        run({4'h9, i[2:0], i[0], 8'h33}, 8'hff);
        cmp(file_wdata, 8'hff & ~(8'h01 << i));
        cmp(file_addr, i[0] ? 12'h333 : 12'h033);
      end
      // A word outside the group only advances the counter and raises unsupported
      run(16'h0000, 8'h00);
      cmp(unsupported, 1'b1);
      cmp(file_we, 1'b0);
      chk(8'h00, 5'h0d);
    end
  endtask
  task final_report;
    begin
      $display("checks=%0d errors=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Reset spans eleven edges; the run needs well under 200 cycles
  initial begin
    repeat (10) @(posedge mclk);
    t_alu;
    t_br;
    final_report;
  end
  initial begin
    #20000;
    bad_count = bad_count + 1;
    final_report;
  end
endmodule
